// [ea_pkg.sv]
// Purpose: shared constants and types for the effective address generator
// Assumes: 32-bit addresses, eight wide address registers
// Notes: no registers reachable by software
package ea_pkg;
  localparam int ADDR_W = 32;
  localparam int REG_COUNT = 8;
  localparam int AREG_FIELD_W = 3;
  localparam int DREG_FIELD_W = 4;
  localparam int BITNUM_W = 3;
  localparam int SHORT_IMM3_W = 3;
  localparam int SHORT_IMM4_W = 4;
  localparam int TRAP_VEC_W = 2;
  localparam int BITFIELD_IMM_W = 8;
  localparam int SHORT_DISP_W = 2;
  localparam int MODE_COUNT = 11;
  localparam logic [31:0] UPPER8_ZERO_MASK = 32'h00ffffff;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] SHORT_BASE_RESET = 32'h00000000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
  typedef enum logic [1:0] {CPU_ADVANCED, CPU_MIDDLE, CPU_NORMAL, CPU_MAXIMUM} cpumode_t;
  typedef enum logic [3:0] {
    AM_REG_DIRECT, AM_REG_INDIRECT, AM_DISP, AM_INDEX, AM_POST_INC, AM_PRE_DEC,
    AM_PRE_INC, AM_POST_DEC, AM_ABSOLUTE, AM_IMMEDIATE, AM_PC_REL, AM_PC_INDEX,
    AM_MEM_INDIRECT, AM_EXT_MEM_INDIRECT
  } amode_t;
  typedef enum logic [1:0] {DISP_SHORT, DISP_16, DISP_32} disp_t;
  typedef enum logic [1:0] {ABS_8, ABS_16, ABS_24, ABS_32} abs_t;
  typedef enum logic [2:0] {IMM_3, IMM_4, IMM_8, IMM_16, IMM_32} imm_t;
  typedef enum logic [1:0] {IDX_BYTE, IDX_WORD, IDX_LONG} idx_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SECOND} state_t;

  function automatic logic [31:0] step_of(input size_t sz);
    unique case (sz)
      SZ_BYTE: step_of = 32'h00000001;
      SZ_WORD: step_of = 32'h00000002;
      default: step_of = 32'h00000004;
    endcase
  endfunction
endpackage

// [operand_extender.sv]
// Purpose: widens immediates and absolute addresses to 32 bits
// Assumes: extension word already right-aligned
// Notes: pure combinational
`timescale 1ns/1ns
module operand_extender
  import ea_pkg::*;
(
  input wire logic [31:0] ext,
  input wire abs_t absKind,
  input wire imm_t immKind,
  input wire logic [31:0] shortAddressBase,
  output logic [31:0] absAddr,
  output logic [31:0] immValue
);
  // ----------------------------------------
  // absolute and immediate widening
  // ----------------------------------------
  wire logic [31:0] abs8 = {shortAddressBase[31:8], ext[7:0]};
  wire logic [31:0] abs16 = {{16{ext[15]}}, ext[15:0]};
  wire logic [31:0] abs24 = {8'h00, ext[23:0]};
  assign absAddr = (absKind == ABS_8) ? abs8 :
                   (absKind == ABS_16) ? abs16 :
                   (absKind == ABS_24) ? abs24 : ext;
  // short immediates zero-extend; callers truncate to operand width
  assign immValue = (immKind == IMM_3) ? {29'h0, ext[2:0]} :
                    (immKind == IMM_4) ? {28'h0, ext[3:0]} :
                    (immKind == IMM_8) ? {24'h0, ext[7:0]} :
                    (immKind == IMM_16) ? {16'h0, ext[15:0]} : ext;
endmodule

// [effective_address_generator.sv]
// Purpose: computes operand effective addresses and address register write-back
// Assumes: decoder supplies fields one cycle ahead; register file outside
// Notes: results registered, address and write-back appear together
// Contract
// - address register field 3 bits; data register field 3 or 4 bits
// - accept 8, 16 or 32 bit extension words
// - support fourteen addressing modes; decoder picks the legal subset
// - bit operands by direct, indirect or absolute; bit number register or 3-bit
// - direct selects 8-bit halves, 16-bit halves or 32-bit registers by size
// - indirect branch target in advanced mode zeroes upper eight bits
// - displacement adds 16-bit sign-extended or 32-bit value to register
// - short 2-bit displacement scales by operand size 1, 2 or 4
// - index byte, word or long zero-extended then scaled then displaced
// - index scale 1, 2 or 4 by operand size
// - post-increment uses old value, writes back plus step
// - pre-decrement writes back minus step and uses it
// - pre-increment writes back plus step and uses it
// - post-decrement uses old value, writes back minus step
// - stored register equal to address register shows updated value
// - second address with same register uses updated value
// - 8-bit absolute takes upper 24 bits from short base
// - 16-bit absolute sign-extended; 32-bit absolute unmodified
// - 24-bit absolute program address has upper eight bits zeroed
// - narrow immediates zero-extended to operand width
// - trap carries 2-bit vector; bit-field ops carry 8-bit immediate
// - pc-relative sign-extends 8/16-bit displacement onto next instruction address
// - middle mode: data sign-extends low 16, branch zeroes upper eight
`timescale 1ns/1ns
module effective_address_generator
  import ea_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic secondOperand,
  input wire amode_t addrMode,
  input wire size_t opSize,
  input wire cpumode_t cpuMode,
  input wire logic isBranch,
  input wire logic [AREG_FIELD_W-1:0] addrRegField,
  input wire logic [DREG_FIELD_W-1:0] dataRegField,
  input wire logic dataFieldWide,
  input wire logic [AREG_FIELD_W-1:0] storeRegField,
  input wire disp_t dispKind,
  input wire logic [SHORT_DISP_W-1:0] shortDisp,
  input wire abs_t absKind,
  input wire imm_t immKind,
  input wire idx_t indexKind,
  input wire logic [31:0] extWord,
  input wire logic [31:0] nextPc,
  input wire logic [31:0] shortAddressBase,
  input wire logic [31:0] regFile [REG_COUNT],
  output logic [31:0] effAddr,
  output logic [31:0] operandValue,
  output logic addrValid,
  output logic regWriteEn,
  output logic [AREG_FIELD_W-1:0] regWriteIdx,
  output logic [31:0] regWriteData,
  output logic [31:0] storeData,
  output logic [BITNUM_W-1:0] bitNumber,
  output logic [TRAP_VEC_W-1:0] trapVector,
  output logic [BITFIELD_IMM_W-1:0] bitFieldMask
);
  // ----------------------------------------
  // forwarding of the previous write-back
  // ----------------------------------------
  // a pending write from the first address calc overrides the register file view
  state_t state;
  logic fwdValid;
  logic [AREG_FIELD_W-1:0] fwdIdx;
  logic [31:0] fwdData;

  function automatic logic [31:0] read_reg(input logic [AREG_FIELD_W-1:0] idx,
                                           input logic [31:0] rf [REG_COUNT],
                                           input logic fv,
                                           input logic [AREG_FIELD_W-1:0] fi,
                                           input logic [31:0] fd);
    read_reg = (fv && fi == idx) ? fd : rf[idx];
  endfunction

  wire logic useFwd = fwdValid && secondOperand && state == ST_SECOND;
  wire logic [31:0] baseReg = read_reg(addrRegField, regFile, useFwd, fwdIdx, fwdData);
  wire logic [2:0] dataIdx = dataFieldWide ? dataRegField[2:0] : dataRegField[2:0];
  wire logic [31:0] dataReg = read_reg(dataIdx, regFile, useFwd, fwdIdx, fwdData);

  // ----------------------------------------
  // register direct selection
  // ----------------------------------------
  // wide field: bit 3 picks upper half (E or H); narrow field always picks the low byte or low half
  wire logic hiPart = dataFieldWide ? dataRegField[3] : 1'b0;
  wire logic [7:0] byteSel = hiPart ? dataReg[15:8] : dataReg[7:0];
  wire logic [15:0] wordSel = hiPart ? dataReg[31:16] : dataReg[15:0];
  wire logic [31:0] directValue = (opSize == SZ_BYTE) ? {24'h0, byteSel} :
                                  (opSize == SZ_WORD) ? {16'h0, wordSel} : dataReg;

  // ----------------------------------------
  // displacement, index and steps
  // ----------------------------------------
  wire logic [31:0] step = step_of(opSize);
  wire logic [31:0] shortScaled = (opSize == SZ_BYTE) ? {30'h0, shortDisp} :
                                  (opSize == SZ_WORD) ? {29'h0, shortDisp, 1'b0} :
                                  {28'h0, shortDisp, 2'b00};
  wire logic [31:0] dispValue = (dispKind == DISP_SHORT) ? shortScaled :
                                (dispKind == DISP_16) ? {{16{extWord[15]}}, extWord[15:0]} :
                                extWord;
  wire logic [31:0] indexRaw = (indexKind == IDX_BYTE) ? {24'h0, baseReg[7:0]} :
                               (indexKind == IDX_WORD) ? {16'h0, baseReg[15:0]} :
                               baseReg;
  wire logic [31:0] indexScaled = (opSize == SZ_BYTE) ? indexRaw :
                                  (opSize == SZ_WORD) ? {indexRaw[30:0], 1'b0} :
                                  {indexRaw[29:0], 2'b00};
  wire logic [31:0] pcDisp = (dispKind == DISP_16) ? {{16{extWord[15]}}, extWord[15:0]} :
                             {{24{extWord[7]}}, extWord[7:0]};
  wire logic [31:0] pcIndexScaled = {indexRaw[30:0], 1'b0};
  wire logic [31:0] incValue = baseReg + step;
  wire logic [31:0] decValue = baseReg - step;

  // ----------------------------------------
  // absolute and immediate forms
  // ----------------------------------------
  logic [31:0] absAddr;
  logic [31:0] immValue;
  operand_extender extender (
    .ext(extWord),
    .absKind(absKind),
    .immKind(immKind),
    .shortAddressBase(shortAddressBase),
    .absAddr(absAddr),
    .immValue(immValue)
  );
  wire logic [31:0] immSized = (opSize == SZ_BYTE) ? {24'h0, immValue[7:0]} :
                               (opSize == SZ_WORD) ? {16'h0, immValue[15:0]} : immValue;

  // ----------------------------------------
  // mode select
  // ----------------------------------------
  // memory-indirect modes only hand back the vector slot address; the fetch is elsewhere
  logic [31:0] rawAddr;
  logic rawValid;
  logic wbEn;
  logic [31:0] wbData;
  always_comb begin
    rawAddr = baseReg;
    rawValid = 1'b1;
    wbEn = 1'b0;
    wbData = baseReg;
    unique case (addrMode)
      AM_REG_DIRECT: rawValid = 1'b0;
      AM_REG_INDIRECT: rawAddr = baseReg;
      AM_DISP: rawAddr = baseReg + dispValue;
      AM_INDEX: rawAddr = indexScaled + dispValue;
      AM_POST_INC: begin
        rawAddr = baseReg;
        wbEn = 1'b1;
        wbData = incValue;
      end
      AM_PRE_DEC: begin
        rawAddr = decValue;
        wbEn = 1'b1;
        wbData = decValue;
      end
      AM_PRE_INC: begin
        rawAddr = incValue;
        wbEn = 1'b1;
        wbData = incValue;
      end
      AM_POST_DEC: begin
        rawAddr = baseReg;
        wbEn = 1'b1;
        wbData = decValue;
      end
      AM_ABSOLUTE: rawAddr = absAddr;
      AM_IMMEDIATE: rawValid = 1'b0;
      AM_PC_REL: rawAddr = nextPc + pcDisp;
      AM_PC_INDEX: rawAddr = nextPc + pcIndexScaled;
      AM_MEM_INDIRECT: rawAddr = {24'h0, extWord[7:0]};
      AM_EXT_MEM_INDIRECT: rawAddr = {23'h0, 1'b1, extWord[6:0], 1'b0};
      default: rawValid = 1'b0;
    endcase
  end

  // ----------------------------------------
  // cpu-mode width masking
  // ----------------------------------------
  wire logic branchMask = isBranch && (cpuMode == CPU_ADVANCED || cpuMode == CPU_MIDDLE);
  wire logic dataMiddle = !isBranch && cpuMode == CPU_MIDDLE;
  wire logic abs24Kind = addrMode == AM_ABSOLUTE && absKind == ABS_24;
  wire logic [31:0] maskedAddr = (branchMask || abs24Kind) ? (rawAddr & UPPER8_ZERO_MASK) :
                                 dataMiddle ? {{16{rawAddr[15]}}, rawAddr[15:0]} :
                                 rawAddr;

  // stored register sees post-update value when it is the address register
  wire logic [31:0] storeRaw = read_reg(storeRegField, regFile, useFwd, fwdIdx, fwdData);
  wire logic [31:0] storeNow = (wbEn && storeRegField == addrRegField) ? wbData : storeRaw;
  wire logic [31:0] next_operand = (addrMode == AM_IMMEDIATE) ? immSized : directValue;

  // ----------------------------------------
  // second-calculation tracking
  // ----------------------------------------
  state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start && wbEn) begin
        next_state = ST_SECOND;
      end
      ST_SECOND: if (start && !wbEn) begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      fwdValid <= 1'b0;
      fwdIdx <= '0;
      fwdData <= ADDR_RESET;
    end else begin
      state <= next_state;
      if (start) begin
        fwdValid <= wbEn;
        fwdIdx <= addrRegField;
        fwdData <= wbData;
      end
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // one stage: address and write-back leave on the same edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      effAddr <= ADDR_RESET;
      addrValid <= 1'b0;
      regWriteEn <= 1'b0;
      regWriteIdx <= '0;
      regWriteData <= ADDR_RESET;
    end else begin
      effAddr <= maskedAddr;
      addrValid <= start && rawValid;
      regWriteEn <= start && wbEn;
      regWriteIdx <= addrRegField;
      regWriteData <= wbData;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      operandValue <= ADDR_RESET;
      storeData <= ADDR_RESET;
      bitNumber <= '0;
      trapVector <= '0;
      bitFieldMask <= '0;
    end else begin
      operandValue <= next_operand;
      storeData <= storeNow;
      bitNumber <= extWord[BITNUM_W-1:0];
      trapVector <= extWord[TRAP_VEC_W-1:0];
      bitFieldMask <= extWord[BITFIELD_IMM_W-1:0];
    end
  end
endmodule

// [reg_file_model.sv]
// Purpose: register file at the far side, taking write-backs and bench loads
// Assumes: a write-back lands on the edge after it is shown
// Notes: a bench load on the same edge wins, so a test can reset a register at once
`timescale 1ns/1ns
module reg_file_model
  import ea_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic loadEn,
  input wire logic [AREG_FIELD_W-1:0] loadIdx,
  input wire logic [31:0] loadData,
  input wire logic regWriteEn,
  input wire logic [AREG_FIELD_W-1:0] regWriteIdx,
  input wire logic [31:0] regWriteData,
  output logic [31:0] regs [REG_COUNT]
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_COUNT; i++) regs[i] <= ADDR_RESET;
    end else begin
      if (regWriteEn) regs[regWriteIdx] <= regWriteData;
      if (loadEn) regs[loadIdx] <= loadData;
    end
  end
endmodule

// [effective_address_generator_chk.sv]
// Purpose: port checks of the effective address generator
// Assumes: arithmetic checks use advanced-mode data accesses only
// Notes: forwarded second calcs are judged by the bench
`timescale 1ns/1ns
module effective_address_generator_chk
  import ea_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic secondOperand,
  input wire amode_t addrMode,
  input wire size_t opSize,
  input wire cpumode_t cpuMode,
  input wire logic isBranch,
  input wire logic [AREG_FIELD_W-1:0] addrRegField,
  input wire logic [AREG_FIELD_W-1:0] storeRegField,
  input wire disp_t dispKind,
  input wire abs_t absKind,
  input wire logic [31:0] extWord,
  input wire logic [31:0] shortAddressBase,
  input wire logic [31:0] regFile [REG_COUNT],
  input wire logic [31:0] effAddr,
  input wire logic addrValid,
  input wire logic regWriteEn,
  input wire logic [31:0] regWriteData,
  input wire logic [31:0] storeData
);
  // ----
  // helpers
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [31:0] stepv;
  logic [31:0] baseReg;
  logic dataReq;
  assign stepv = opSize == SZ_BYTE ? 32'h1 : (opSize == SZ_WORD ? 32'h2 : 32'h4);
  assign baseReg = regFile[addrRegField];
  // forwarding changes the base, so second calcs are kept out
  assign dataReq = start && !secondOperand && cpuMode == CPU_ADVANCED && !isBranch;
  property p_post_inc; dataReq && addrMode == AM_POST_INC |=> addrValid &&
    effAddr == $past(baseReg) && regWriteData == $past(baseReg) + $past(stepv); endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
  property p_pre_dec; dataReq && addrMode == AM_PRE_DEC |=>
    effAddr == $past(baseReg) - $past(stepv) && regWriteData == effAddr; endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement wrong");
  property p_pre_inc; dataReq && addrMode == AM_PRE_INC |=>
    effAddr == $past(baseReg) + $past(stepv) && regWriteData == effAddr; endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre increment wrong");
  property p_post_dec; dataReq && addrMode == AM_POST_DEC |=> effAddr == $past(baseReg)
    && regWriteData == $past(baseReg) - $past(stepv); endproperty
  a_post_dec: assert property (p_post_dec) else $error("post decrement wrong");
  property p_disp16; dataReq && addrMode == AM_DISP && dispKind == DISP_16 |=> effAddr ==
    $past(baseReg) + {{16{$past(extWord[15])}}, $past(extWord[15:0])}; endproperty
  a_disp16: assert property (p_disp16) else $error("displacement wrong");
  property p_abs8; dataReq && addrMode == AM_ABSOLUTE && absKind == ABS_8 |=>
    effAddr == {$past(shortAddressBase[31:8]), $past(extWord[7:0])}; endproperty
  a_abs8: assert property (p_abs8) else $error("short absolute wrong");
  property p_abs16; dataReq && addrMode == AM_ABSOLUTE && absKind == ABS_16 |=>
    effAddr == {{16{$past(extWord[15])}}, $past(extWord[15:0])}; endproperty
  a_abs16: assert property (p_abs16) else $error("word absolute wrong");
  property p_abs24; start && addrMode == AM_ABSOLUTE && absKind == ABS_24 |=>
    effAddr == ($past(extWord) & UPPER8_ZERO_MASK); endproperty
  a_abs24: assert property (p_abs24) else $error("program absolute wrong");
  property p_together; regWriteEn |-> addrValid; endproperty
  a_together: assert property (p_together) else $error("write-back without address");
  property p_store; dataReq && addrMode == AM_POST_INC && storeRegField == addrRegField
    |=> storeData == regWriteData; endproperty
  a_store: assert property (p_store) else $error("store value not updated");
  cover property (dataReq && addrMode == AM_POST_INC);
  cover property (start && secondOperand);
  cover property (start && addrMode == AM_ABSOLUTE);
endmodule
bind effective_address_generator effective_address_generator_chk i_effective_address_generator_chk (.*);

// [tb_effective_address_generator.sv]
// Purpose: self-checking bench of the effective address generator
// Assumes: advanced mode except one middle-mode absolute access; the register file model takes write-backs
// Notes: one idle cycle follows each checked request, except the back-to-back pair in t_forward, so start never toggles twice at once
`timescale 1ns/1ns
module tb_effective_address_generator
  import ea_pkg::*;
;
  logic mclk = 0, resetn = 0, start = 0, secondOperand = 0, isBranch = 0;
  logic dataFieldWide = 0, loadEn = 0, addrValid, regWriteEn;
  amode_t addrMode = AM_REG_DIRECT;
  size_t opSize = SZ_BYTE;
  cpumode_t cpuMode = CPU_ADVANCED;
  logic [2:0] addrRegField = '0, storeRegField = '0, loadIdx = '0, regWriteIdx, bitNumber;
  logic [3:0] dataRegField = '0;
  disp_t dispKind = DISP_16;
  abs_t absKind = ABS_32;
  imm_t immKind = IMM_8;
  idx_t indexKind = IDX_LONG;
  logic [1:0] shortDisp = '0, trapVector;
  logic [7:0] bitFieldMask;
  logic [31:0] extWord = '0, nextPc = '0, shortAddressBase = '0, loadData = '0;
  logic [31:0] effAddr, operandValue, regWriteData, storeData;
  logic [31:0] regFile [REG_COUNT];
  int miscompares = 0, samples_checked = 0;
  effective_address_generator i_effective_address_generator (.*);
  reg_file_model i_reg_file_model (.mclk(mclk), .resetn(resetn), .loadEn(loadEn),
    .loadIdx(loadIdx), .loadData(loadData), .regWriteEn(regWriteEn),
    .regWriteIdx(regWriteIdx), .regWriteData(regWriteData), .regs(regFile));
  always #5 mclk = ~mclk;
  // ----
  // shared tasks
  // ----
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [2:0] idx, input logic [31:0] val);
    loadIdx = idx;
    loadData = val;
    loadEn = 1'b1;
    @(negedge mclk);
    loadEn = 1'b0;
  endtask
  // results are registered, so they are read at the next falling edge
  task automatic go();
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask
  task automatic ea(input amode_t md, input logic [31:0] ext, input logic [31:0] exp);
    addrMode = md;
    extWord = ext;
    go();
    chk(effAddr, exp);
    @(negedge mclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_incdec();
    logic [31:0] s, w;
    for (int m = 0; m < 4; m++) begin
      for (int z = 0; z < 3; z++) begin
        s = 32'h1 << z;
        w = (m == 0 || m == 2) ? 32'h1000 + s : 32'h1000 - s;
        load(3'h2, 32'h00001000);
        addrMode = amode_t'(4 + m);
        opSize = size_t'(z);
        addrRegField = 3'h2;
        storeRegField = 3'h2;
        go();
        chk(effAddr, (m == 1 || m == 2) ? w : 32'h1000);
        chk(regWriteData, w);
        chk(storeData, w);
        chk({31'h0, regWriteEn & addrValid}, 32'h1);
        chk({29'h0, regWriteIdx}, 32'h2);
      end
    end
  endtask
  task automatic t_forward();
    load(3'h0, 32'h00001000);
    addrMode = AM_POST_INC;
    opSize = SZ_BYTE;
    addrRegField = 3'h0;
    start = 1'b1;
    @(negedge mclk);
    chk(effAddr, 32'h00001000);
    secondOperand = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    secondOperand = 1'b0;
    chk(effAddr, 32'h00001001);
    chk(regWriteData, 32'h00001002);
  endtask
  task automatic t_disp();
    load(3'h3, 32'h00002000);
    addrRegField = 3'h3;
    opSize = SZ_LONG;
    dispKind = DISP_16;
    ea(AM_DISP, 32'h0000fff0, 32'h00001ff0);
    dispKind = DISP_32;
    ea(AM_DISP, 32'h10000000, 32'h10002000);
    dispKind = DISP_SHORT;
    shortDisp = 2'h3;
    ea(AM_DISP, 32'h00000000, 32'h0000200c);
    load(3'h3, 32'hffff8003);
    dispKind = DISP_16;
    indexKind = IDX_WORD;
    ea(AM_INDEX, 32'h00000010, 32'h0002001c);
    opSize = SZ_BYTE;
    indexKind = IDX_BYTE;
    ea(AM_INDEX, 32'h00000010, 32'h00000013);
  endtask
  task automatic t_abs();
    shortAddressBase = 32'h12345600;
    absKind = ABS_8;
    ea(AM_ABSOLUTE, 32'h000000ab, 32'h123456ab);
    absKind = ABS_16;
    ea(AM_ABSOLUTE, 32'h00008000, 32'hffff8000);
    absKind = ABS_32;
    ea(AM_ABSOLUTE, 32'hfedc0000, 32'hfedc0000);
    absKind = ABS_24;
    ea(AM_ABSOLUTE, 32'hffabcdef, 32'h00abcdef);
    load(3'h3, 32'hff345678);
    isBranch = 1'b1;
    ea(AM_REG_INDIRECT, 32'h00000000, 32'h00345678);
    isBranch = 1'b0;
  endtask
  task automatic t_direct();
    load(3'h5, 32'h89abcdef);
    addrMode = AM_REG_DIRECT;
    dataFieldWide = 1'b1;
    dataRegField = 4'hd;
    opSize = SZ_BYTE;
    go();
    chk(operandValue, 32'h000000cd);
    chk({31'h0, addrValid}, 32'h0);
    @(negedge mclk);
    opSize = SZ_WORD;
    go();
    chk(operandValue, 32'h000089ab);
    @(negedge mclk);
    dataFieldWide = 1'b0;
    dataRegField = 4'h5;
    opSize = SZ_LONG;
    go();
    chk(operandValue, 32'h89abcdef);
    @(negedge mclk);
    nextPc = 32'h00001000;
    dispKind = DISP_16;
    isBranch = 1'b1;
    ea(AM_PC_REL, 32'h0000fffe, 32'h00000ffe);
    isBranch = 1'b0;
    cpuMode = CPU_MIDDLE;
    absKind = ABS_32;
    ea(AM_ABSOLUTE, 32'h00018000, 32'hffff8000);
    cpuMode = CPU_ADVANCED;
  endtask
  task automatic t_imm();
    immKind = IMM_16;
    opSize = SZ_LONG;
    addrMode = AM_IMMEDIATE;
    extWord = 32'h00008005;
    go();
    chk(operandValue, 32'h00008005);
    chk({31'h0, addrValid}, 32'h0);
    chk({29'h0, bitNumber}, 32'h5);
    chk({30'h0, trapVector}, 32'h1);
    chk({24'h0, bitFieldMask}, 32'h05);
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    t_incdec();
    t_forward();
    t_disp();
    t_abs();
    t_direct();
    t_imm();
    results();
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule
